/* File: fbmc_pkg.sv */
// Package for the flash bus mode controller: pin groups, timing counts, commands.
// Assumes a 100 MHz core clock and an asynchronous x16 parallel flash on the pins.
package fbmc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int ADDR_ACCESS_PS = 70000;        // address_access_time
  localparam int CE_ACCESS_PS = 70000;          // chip-select access time
  localparam int WR_PULSE_PS = 35000;           // write strobe low time
  localparam int WR_HIGH_PS = 20000;            // write strobe high time
  localparam int RESET_PULSE_MIN_PS = 500000;   // reset_pulse_min
  localparam int RESET_RELEASE_PS = 50000;      // reset_release_delay
  localparam int RESET_READY_PS = 20000000;     // reset_ready_time
  localparam int ACC_SETTLE_PS = 1000000;       // accel level settle time
  localparam int SLEEP_EXTRA_PS = 150000;       // stable address time beyond access time before sleep

  // Least times round up
  localparam int ADDR_ACCESS_CYC = (ADDR_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CE_ACCESS_CYC = (CE_ACCESS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RD_WAIT_CYC = (CE_ACCESS_CYC > ADDR_ACCESS_CYC) ? CE_ACCESS_CYC : ADDR_ACCESS_CYC;
  localparam int WR_PULSE_CYC = (WR_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WR_HIGH_CYC = (WR_HIGH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_RELEASE_CYC = (RESET_RELEASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_READY_CYC = (RESET_READY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_SETTLE_CYC = (ACC_SETTLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SLEEP_CYC = ADDR_ACCESS_CYC + (SLEEP_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int CNT_W = 24;

  // ----------------------------------------------------------------
  // Widths and address map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int BANK_LSB = 20;                 // A22-A20 select the bank
  localparam int SECT_LSB = 12;                 // A22-A12 select the sector
  localparam logic [2:0] BANK_FIRST = 3'h0;
  localparam logic [2:0] BANK_LAST = 3'h7;
  localparam int SMALL_SECTORS = 8;             // 4 Kword sectors at the base
  localparam int SMALL_PER_BIG = 8;             // 4 Kword blocks per 32 Kword sector

  // ----------------------------------------------------------------
  // Host command port
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FBMC_OP_READ  = 3'h0,
    FBMC_OP_WRITE = 3'h1,
    FBMC_OP_RESET = 3'h2,
    FBMC_OP_ACC   = 3'h3,
    FBMC_OP_NOACC = 3'h4
  } fbmc_op_t;

  typedef struct packed {
    fbmc_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } fbmc_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]   rdata;
    logic [2:0]          bank;
    logic [6:0]          sector;
  } fbmc_rsp_t;

  // Pins driven toward the flash
  typedef struct packed {
    logic                chip_select_n;
    logic                write_strobe_n;
    logic                output_gate_n;
    logic                hardware_clear_n;
    logic                accel_level;    // 1 requests accelerated_program_level
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data_out;
    logic                data_oe_n;
  } fbmc_pins_t;

  // First bank sector number from a word address
  function automatic logic [6:0] fbmc_sector(input logic [ADDR_W-1:0] a);
    logic [10:0] s;
    s = a[ADDR_W-1:SECT_LSB];
    if (s[10:3] == 8'h00)
      fbmc_sector = {4'h0, s[2:0]};
    else
      fbmc_sector = 7'(s[10:3] + 8'(SMALL_SECTORS - 1));
  endfunction

endpackage

/* File: fbmc_ctrl.sv */
// Host-side controller that runs read, command-write, reset and accelerate cycles
// on an asynchronous x16 NOR flash. Requests arrive on a valid/ready port in core_clk.
`timescale 1ns/100ps
`default_nettype none

// Flash device rules that bear on this block
// - Command writes drive chip select and write strobe low with output gate high.
// - In fast program mode a word program is two write cycles, not four.
// - Apply accelerated level only for programming; otherwise drive the pin high. The block drives accel_level 0 when not accelerating.
// - Reads from standby wait the full chip-select access time before sampling.
// - Host reissues an interrupted operation once the device accepts commands again.
// - Reads start only after the release delay following reset going high.
// - Array read drives output gate and chip select low, write strobe high.
module fbmc_ctrl
(
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire fbmc_pkg::fbmc_req_t          req,
  output logic                              rsp_valid,
  output fbmc_pkg::fbmc_rsp_t               rsp,
  output logic                              op_aborted,
  output logic                              flash_busy,
  output fbmc_pkg::fbmc_pins_t              pins,
  input  wire logic [fbmc_pkg::DATA_W-1:0]  data_in,
  input  wire logic                         ready_busy_n
);
  import fbmc_pkg::*;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_RD    = 8'h02,
    ST_WRLO  = 8'h04,
    ST_WRHI  = 8'h08,
    ST_RSTLO = 8'h10,
    ST_RSTBZ = 8'h20,
    ST_RSTRH = 8'h40,
    ST_ACC   = 8'h80
  } fbmc_state_t;

  fbmc_state_t         state_r;
  fbmc_state_t         state_nxt;
  logic [CNT_W-1:0]    cnt_r;
  fbmc_pins_t          pins_r;
  fbmc_pins_t          pins_nxt;
  fbmc_req_t           req_r;
  logic                rsp_valid_r;
  fbmc_rsp_t           rsp_r;
  logic                abort_r;
  logic                busy_seen_r;
  logic [2:0]          rb_sync_r;
  logic                rb_level_r;

  // ----------------------------------------------------------------
  // Ready/busy input synchroniser
  // ----------------------------------------------------------------
  // Three stages; level changes once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rb_sync_r  <= 3'h7;
      rb_level_r <= 1'b1;
    end
    else
    begin
      rb_sync_r <= {rb_sync_r[1:0], ready_busy_n};
      if (rb_sync_r[1] == rb_sync_r[2])
        rb_level_r <= rb_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Count finished and request acceptance terms
  wire cnt_done  = (cnt_r == '0);
  wire take_req  = req_valid && (state_r == ST_IDLE) && rb_level_r;
  wire take_rst  = req_valid && (state_r == ST_IDLE) && (req.op == FBMC_OP_RESET);
  wire was_busy  = !rb_level_r;
  wire from_stby = pins_r.chip_select_n;

  // ----------------------------------------------------------------
  // Next state and pin values
  // ----------------------------------------------------------------
  // Idle pins: deselected (standby), outputs gated, bus released
  always_comb
  begin
    state_nxt = state_r;
    pins_nxt = pins_r;
    unique case (state_r)
      ST_IDLE:
      begin
        pins_nxt.chip_select_n  = 1'b1;
        pins_nxt.write_strobe_n = 1'b1;
        pins_nxt.output_gate_n  = 1'b1;
        pins_nxt.data_oe_n      = 1'b1;
        if (take_rst)
        begin
          pins_nxt.hardware_clear_n = 1'b0;
          state_nxt = ST_RSTLO;
        end
        else if (take_req)
        begin
          pins_nxt.addr = req.addr;
          unique case (req.op)
            FBMC_OP_READ:
            begin
              pins_nxt.chip_select_n = 1'b0;
              pins_nxt.output_gate_n = 1'b0;
              state_nxt = ST_RD;
            end
            FBMC_OP_WRITE:
            begin
              pins_nxt.chip_select_n  = 1'b0;
              pins_nxt.write_strobe_n = 1'b0;
              pins_nxt.data_out       = req.wdata;
              pins_nxt.data_oe_n      = 1'b0;
              state_nxt = ST_WRLO;
            end
            FBMC_OP_ACC:
            begin
              pins_nxt.accel_level = 1'b1;
              state_nxt = ST_ACC;
            end
            FBMC_OP_NOACC:
            begin
              pins_nxt.accel_level = 1'b0;
              state_nxt = ST_ACC;
            end
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_RD:
        if (cnt_done)
          state_nxt = ST_IDLE;
      ST_WRLO:
        if (cnt_done)
        begin
          pins_nxt.write_strobe_n = 1'b1;
          state_nxt = ST_WRHI;
        end
      ST_WRHI:
        if (cnt_done)
        begin
          pins_nxt.chip_select_n = 1'b1;
          pins_nxt.data_oe_n     = 1'b1;
          state_nxt = ST_IDLE;
        end
      ST_RSTLO:
        if (cnt_done)
        begin
          pins_nxt.hardware_clear_n = 1'b1;
          state_nxt = ST_RSTBZ;
        end
      ST_RSTBZ:
        if (rb_level_r || cnt_done)
          state_nxt = ST_RSTRH;
      ST_RSTRH:
        if (cnt_done)
          state_nxt = ST_IDLE;
      ST_ACC:
        if (cnt_done)
          state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Wait counter load values
  // ----------------------------------------------------------------
  // Read from standby waits the longer of chip-select and address access time; with chip select already low, address access only
  logic [CNT_W-1:0] cnt_load;
  always_comb
  begin
    cnt_load = '0;
    unique case (state_nxt)
      ST_RD:    cnt_load = from_stby ? CNT_W'(RD_WAIT_CYC - 1) : CNT_W'(ADDR_ACCESS_CYC - 1);
      ST_WRLO:  cnt_load = CNT_W'(WR_PULSE_CYC - 1);
      ST_WRHI:  cnt_load = CNT_W'(WR_HIGH_CYC - 1);
      ST_RSTLO: cnt_load = CNT_W'(RESET_PULSE_CYC - 1);
      ST_RSTBZ: cnt_load = CNT_W'(RESET_READY_CYC - 1);
      ST_RSTRH: cnt_load = CNT_W'(RESET_RELEASE_CYC - 1);
      ST_ACC:   cnt_load = CNT_W'(ACC_SETTLE_CYC - 1);
      default:  cnt_load = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // State, counter and pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      pins_r  <= '{chip_select_n: 1'b1, write_strobe_n: 1'b1, output_gate_n: 1'b1,
                   hardware_clear_n: 1'b1, accel_level: 1'b0, addr: '0,
                   data_out: '0, data_oe_n: 1'b1};
    end
    else
    begin
      state_r <= state_nxt;
      pins_r  <= pins_nxt;
      cnt_r   <= (state_nxt != state_r) ? cnt_load : (cnt_done ? cnt_r : cnt_r - 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Request capture, response and abort flag
  // ----------------------------------------------------------------
  // Read data sampled on the final wait cycle; abort marks a reset over busy device
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_r       <= '0;
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
      abort_r     <= 1'b0;
      busy_seen_r <= 1'b0;
    end
    else
    begin
      if (take_req || take_rst)
        req_r <= req;
      rsp_valid_r <= 1'b0;
      if (take_rst)
        busy_seen_r <= was_busy;
      if (state_r == ST_RD && cnt_done)
      begin
        rsp_valid_r <= 1'b1;
        rsp_r.rdata  <= data_in;
        rsp_r.bank   <= req_r.addr[ADDR_W-1:BANK_LSB];
        rsp_r.sector <= fbmc_sector(req_r.addr);
      end
      else if (state_r == ST_WRHI && cnt_done)
        rsp_valid_r <= 1'b1;
      else if (state_r == ST_RSTRH && cnt_done)
      begin
        rsp_valid_r <= 1'b1;
        abort_r     <= busy_seen_r;
      end
      else if (state_r == ST_ACC && cnt_done)
        rsp_valid_r <= 1'b1;
      if (take_req)
        abort_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Ready and busy mirror registered state; program/erase keep running if deselected
  logic req_ready_r;
  logic busy_r;
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      req_ready_r <= 1'b0;
      busy_r      <= 1'b0;
    end
    else
    begin
      req_ready_r <= (state_nxt == ST_IDLE) && !(take_req || take_rst);
      busy_r      <= !rb_level_r;
    end
  end

  assign req_ready  = req_ready_r;
  assign rsp_valid  = rsp_valid_r;
  assign rsp        = rsp_r;
  assign op_aborted = abort_r;
  assign flash_busy = busy_r;
  assign pins       = pins_r;

endmodule

`default_nettype wire

/* File: fbmc_ctrl_props.sv */
// Assertions on the pins and reply port of fbmc_ctrl.
// Sees only the top ports; bound into every fbmc_ctrl below.
`timescale 1ns/100ps
`default_nettype none
module fbmc_ctrl_props
(
  input wire logic                         core_clk,
  input wire logic                         rst,
  input wire logic                         req_valid,
  input wire logic                         req_ready,
  input wire fbmc_pkg::fbmc_req_t          req,
  input wire logic                         rsp_valid,
  input wire fbmc_pkg::fbmc_rsp_t          rsp,
  input wire logic                         op_aborted,
  input wire logic                         flash_busy,
  input wire fbmc_pkg::fbmc_pins_t         pins,
  input wire logic [fbmc_pkg::DATA_W-1:0]  data_in,
  input wire logic                         ready_busy_n
);
  import fbmc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  int unsigned clr_cnt_r;

  // Cycles the reset pin has been low
  always_ff @(posedge core_clk)
    clr_cnt_r <= pins.hardware_clear_n ? 32'h0 : clr_cnt_r + 32'h1;

  // ---
  // Pin and reply checks
  // ---
  a_cmd_gate: assert property (!pins.write_strobe_n |-> !pins.chip_select_n && pins.output_gate_n)
    else $error("write strobe low without select or with gate low");
  a_read_strobe: assert property (!pins.output_gate_n |-> pins.write_strobe_n)
    else $error("output gate low while write strobe low");
  a_bus_free: assert property (!pins.data_oe_n |-> pins.output_gate_n)
    else $error("host drives data while flash outputs enabled");
  a_read_wait: assert property ($fell(pins.output_gate_n) |-> !pins.output_gate_n [*7])
    else $error("read shorter than access time");
  a_write_pulse: assert property ($fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*4])
    else $error("write strobe pulse too short");
  a_clear_width: assert property ($rose(pins.hardware_clear_n) |-> clr_cnt_r >= RESET_PULSE_CYC)
    else $error("reset pulse too short");
  a_release_gap: assert property ($rose(pins.hardware_clear_n) |-> pins.chip_select_n [*5])
    else $error("access too soon after reset release");
  a_busy_seen: assert property ($fell(ready_busy_n) |-> ##[1:5] flash_busy)
    else $error("busy pin not reflected");
  a_bank_field: assert property (rsp_valid && $past(!pins.output_gate_n) |-> rsp.bank == $past(pins.addr[22:20]))
    else $error("bank field differs from read address");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("reply valid longer than one cycle");
endmodule
bind fbmc_ctrl fbmc_ctrl_props i_props (.core_clk, .rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp,
  .op_aborted, .flash_busy, .pins, .data_in, .ready_busy_n);
`default_nettype wire

/* File: fbmc_flash_model.sv */
// Behavioural x16 flash seen by fbmc_ctrl: 16 words, protection, identifier, busy, erase, sleep.
// Assumes the controller's registered pins in the core_clk domain.
`timescale 1ns/100ps
`default_nettype none
module fbmc_flash_model
(
  input  wire logic                 core_clk,
  input  wire fbmc_pkg::fbmc_pins_t pins,
  input  wire logic [15:0]          busy_len,
  output logic [15:0]               data_in,
  output logic                      ready_busy_n
);
  import fbmc_pkg::*;
  localparam logic [15:0] ID_WORD = 16'h5a01;  // Arbitrary identifier value
  localparam logic [15:0] CMD_ID  = 16'h0090;  // Identifier mode entry word
  localparam logic [15:0] CMD_ERS = 16'h0030;  // Erase the word slot at the address
  localparam logic [15:0] CMD_ALL = 16'h0010;  // Erase every word slot
  logic [15:0] mem_r [16];
  logic [15:0] busy_r = 16'h0;
  logic [15:0] last_r = 16'h0;
  logic [7:0]  acc_cnt_r = 8'h0;
  logic [7:0]  still_r = 8'h0;
  logic [22:0] addr_q_r = 23'h0;
  logic [15:0] held_r = 16'h0;
  logic [3:0]  wr_idx_r = 4'h0;
  logic        we_q_r = 1'b1;
  logic        ident_r = 1'b0;
  logic        accel_r = 1'b0;

  // Decode of read, write end and protected first sector
  wire rd_on = !pins.chip_select_n && !pins.output_gate_n && pins.hardware_clear_n;
  wire [15:0] rd_val = ident_r ? ID_WORD : mem_r[pins.addr[3:0]];
  wire wr_end = pins.write_strobe_n && !we_q_r && !pins.chip_select_n;
  wire prot = pins.addr[22:12] == 11'h0 && !accel_r;
  wire addr_chg = pins.addr != addr_q_r;
  wire asleep = still_r >= 8'(SLEEP_CYC);
  // Until the access time has run the bus shows a changing pattern; asleep, the latched word
  assign data_in = (rd_on && acc_cnt_r >= 8'(CE_ACCESS_CYC - 1)) ? (asleep ? held_r : rd_val) : ~last_r;
  assign ready_busy_n = busy_r == 16'h0;
  initial for (int i = 0; i < 16; i++) mem_r[i] = 16'h0;

  // Write capture, busy timing and reset behaviour
  always @(posedge core_clk)
  begin
    we_q_r <= pins.write_strobe_n;
    accel_r <= pins.accel_level;
    last_r <= data_in;
    addr_q_r <= pins.addr;
    acc_cnt_r <= !rd_on ? 8'h0 : (addr_chg ? 8'h1 : acc_cnt_r + 8'h1);
    still_r <= (addr_chg || wr_end || !pins.hardware_clear_n) ? 8'h0 : (asleep ? still_r : still_r + 8'h1);
    if (!asleep) held_r <= rd_val;
    if (!pins.hardware_clear_n)
    begin
      ident_r <= 1'b0;
      if (busy_r != 16'h0)
      begin
        busy_r <= 16'h0040;
        mem_r[wr_idx_r] <= 16'hffff;
      end
    end
    else if (wr_end && pins.data_out == CMD_ID) ident_r <= 1'b1;
    else if (wr_end && pins.data_out == CMD_ALL)
      for (int i = 0; i < 16; i++) mem_r[i] <= 16'hffff;
    else if (wr_end && pins.data_out == CMD_ERS && !prot) mem_r[pins.addr[3:0]] <= 16'hffff;
    else if (wr_end && !prot)
    begin
      mem_r[pins.addr[3:0]] <= pins.data_out;
      wr_idx_r <= pins.addr[3:0];
      busy_r <= accel_r ? busy_len >> 1 : busy_len;
    end
    else if (busy_r != 16'h0) busy_r <= busy_r - 16'h1;
  end
endmodule
`default_nettype wire

/* File: test_flash_bus_mode_control.sv */
// Self-checking bench for fbmc_ctrl with the behavioural flash model.
// Assumes the model's identifier word 16'h5a01 and command word 16'h0090.
`timescale 1ns/100ps
`default_nettype none
module test_flash_bus_mode_control;
  import fbmc_pkg::*;
  localparam int LIMIT = 20000;
  logic        core_clk, rst, req_valid;
  logic        req_ready, rsp_valid, op_aborted, flash_busy, ready_busy_n;
  fbmc_req_t   req;
  fbmc_rsp_t   rsp;
  fbmc_pins_t  pins;
  logic [15:0] data_in, busy_len;
  int          num_errors, tests_run, cyc;

  fbmc_ctrl i_dut (.core_clk, .rst, .req_valid, .req_ready, .req, .rsp_valid, .rsp,
    .op_aborted, .flash_busy, .pins, .data_in, .ready_busy_n);
  fbmc_flash_model i_flash (.core_clk, .pins, .busy_len, .data_in, .ready_busy_n);

  // Clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      num_errors++;
      results();
    end
  end

  // ---
  // Shared tasks
  // ---
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic do_op(input fbmc_op_t op, input logic [22:0] a, input logic [15:0] d);
    if (op != FBMC_OP_RESET)
    begin
      repeat (4) @(posedge core_clk);
      #1;
      while (flash_busy !== 1'b0) begin @(posedge core_clk); #1; end
    end
    req = '{op, a, d};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin @(posedge core_clk); #1; end
    // Hold the request until the take drops ready
    @(posedge core_clk);
    #1;
    while (req_ready === 1'b1) begin @(posedge core_clk); #1; end
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1) begin @(posedge core_clk); #1; end
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd_chk(input logic [22:0] a, input logic [15:0] exp);
    do_op(FBMC_OP_READ, a, 16'h0);
    chk(rsp.rdata, exp, "read data");
  endtask

  // ---
  // Scenarios
  // ---
  task automatic t_map;
    logic [22:0] adr [5] = '{23'h007fff, 23'h008000, 23'h010000, 23'h0fffff, 23'h700000};
    logic [6:0] sec [5] = '{7'h07, 7'h08, 7'h09, 7'h26, 7'h00};
    for (int i = 0; i < 5; i++)
    begin
      do_op(FBMC_OP_READ, adr[i], 16'h0);
      chk(16'(rsp.bank), 16'(adr[i][22:20]), "bank");
      if (i < 4) chk(16'(rsp.sector), 16'(sec[i]), "sector");
    end
    $display("test map done");
  endtask
  task automatic t_accel;
    do_op(FBMC_OP_WRITE, 23'h100003, 16'ha5c3);
    rd_chk(23'h100003, 16'ha5c3);
    do_op(FBMC_OP_WRITE, 23'h000005, 16'h1234);
    rd_chk(23'h000005, 16'h0000);
    do_op(FBMC_OP_ACC, 23'h0, 16'h0);
    chk(16'(pins.accel_level), 16'h1, "accel pin");
    do_op(FBMC_OP_WRITE, 23'h000005, 16'h1234);
    rd_chk(23'h000005, 16'h1234);
    do_op(FBMC_OP_NOACC, 23'h0, 16'h0);
    chk(16'(pins.accel_level), 16'h0, "accel pin");
    do_op(FBMC_OP_WRITE, 23'h000005, 16'h5678);
    rd_chk(23'h000005, 16'h1234);
    $display("test accel done");
  endtask
  task automatic t_ident;
    do_op(FBMC_OP_WRITE, 23'h000555, 16'h0090);
    rd_chk(23'h000000, 16'h5a01);
    do_op(FBMC_OP_RESET, 23'h0, 16'h0);
    chk(16'(op_aborted), 16'h0, "abort flag idle reset");
    rd_chk(23'h100003, 16'ha5c3);
    $display("test ident done");
  endtask
  task automatic t_abort;
    int t0;
    busy_len = 16'h05dc;
    do_op(FBMC_OP_WRITE, 23'h100004, 16'hbeef);
    while (flash_busy !== 1'b1) begin @(posedge core_clk); #1; end
    t0 = cyc;
    do_op(FBMC_OP_RESET, 23'h0, 16'h0);
    chk(16'(op_aborted), 16'h1, "abort flag busy reset");
    chk(16'(cyc - t0 < 1000), 16'h1, "reset wait");
    busy_len = 16'h0014;
    do_op(FBMC_OP_WRITE, 23'h100004, 16'hbeef);
    chk(16'(op_aborted), 16'h0, "abort flag cleared");
    rd_chk(23'h100004, 16'hbeef);
    $display("test abort done");
  endtask
  task automatic t_erase;
    do_op(FBMC_OP_WRITE, 23'h100004, 16'h0030);
    rd_chk(23'h100004, 16'hffff);
    rd_chk(23'h100003, 16'ha5c3);
    do_op(FBMC_OP_WRITE, 23'h100000, 16'h0010);
    rd_chk(23'h100003, 16'hffff);
    $display("test erase done");
  endtask

  task automatic results;
    $display("tests_run %0d num_errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    busy_len = 16'h0014;
    repeat (4) @(posedge core_clk);
    #1 rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_map();
    t_accel();
    t_ident();
    t_abort();
    t_erase();
    results();
  end
endmodule
`default_nettype wire
